// file: qdfl_top.sv
// Quad converter serial frame loader: receiver, decode and channel registers
`timescale 1ns/100ps
module qdfl_top (
  input  wire logic                                            clock,
  input  wire logic                                            rstn,
  input  wire logic                                            sclk,
  input  wire logic                                            sync_n,
  input  wire logic                                            sdin,
  input  wire logic                                            clear_n,
  input  wire logic                                            clear_level_select,
  output logic [qdfl_pkg::NUM_CH-1:0][qdfl_pkg::CODE_W-1:0]    ch_code,
  output logic [qdfl_pkg::NUM_CH-1:0]                          ch_powered_down,
  output logic [qdfl_pkg::NUM_CH-1:0][1:0]                     ch_pd_mode,
  output logic                                                 frame_applied,
  output logic                                                 frame_format_err
);
  import qdfl_pkg::*;

  qdfl_link_if link ();

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  qdfl_rx u_rx (
    .sclk    (sclk),
    .sync_n  (sync_n),
    .sdin    (sdin),
    .clear_n (clear_n),
    .link    (link.rx)
  );

  // ----------------------------------------
  // Crossings into the clock domain
  // ----------------------------------------
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic clr_s1_q;
  logic clr_s2_q;
  logic lvl_s1_q;
  logic lvl_s2_q;
  logic tgl_s1_d;
  logic tgl_s2_d;
  logic tgl_s3_d;
  logic clr_s1_d;
  logic clr_s2_d;
  logic lvl_s1_d;
  logic lvl_s2_d;

  always_comb
  begin
    tgl_s1_d = link.done_tgl;
    tgl_s2_d = tgl_s1_q;
    tgl_s3_d = tgl_s2_q;
    clr_s1_d = clear_n;
    clr_s2_d = clr_s1_q;
    lvl_s1_d = clear_level_select;
    lvl_s2_d = lvl_s1_q;
    if (!rstn)
    begin
      tgl_s1_d = 1'b0;
      tgl_s2_d = 1'b0;
      tgl_s3_d = 1'b0;
      clr_s1_d = 1'b0;
      clr_s2_d = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    tgl_s1_q <= tgl_s1_d;
    tgl_s2_q <= tgl_s2_d;
    tgl_s3_q <= tgl_s3_d;
    clr_s1_q <= clr_s1_d;
    clr_s2_q <= clr_s2_d;
    lvl_s1_q <= lvl_s1_d;
    lvl_s2_q <= lvl_s2_d;
  end

  // ----------------------------------------
  // Asynchronous clear hold
  // ----------------------------------------
  logic clr_hold_q;
  logic clr_hold_d;

  always_comb
  begin
    clr_hold_d = ~clr_s2_q;
  end

  // Set at once by clear low, released after the synchronised clear rises
  always_ff @(posedge clock or negedge clear_n)
  begin
    if (!clear_n)
      clr_hold_q <= 1'b1;
    else
      clr_hold_q <= clr_hold_d;
  end

  logic [CODE_W-1:0] clear_code;
  assign clear_code = lvl_s2_q ? MIDSCALE_CODE : ZEROSCALE_CODE;

  // ----------------------------------------
  // Frame capture in the clock domain
  // ----------------------------------------
  logic               init;
  logic               new_frame;
  logic               apply_q;
  logic               apply_d;
  logic [FRAME_W-1:0] cap_q;
  logic [FRAME_W-1:0] cap_d;

  assign init      = ~rstn | clr_hold_q;
  assign new_frame = tgl_s2_q ^ tgl_s3_q;

  // Receiver word copied once per toggle, decode reads only local state
  always_comb
  begin
    cap_d   = cap_q;
    apply_d = 1'b0;
    if (init)
      cap_d = '0;
    else if (new_frame)
    begin
      cap_d   = link.frame;
      apply_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    cap_q   <= cap_d;
    apply_q <= apply_d;
  end

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  logic              load_cmd_hi;
  logic              load_cmd_lo;
  logic [1:0]        load_cmd;
  logic [SEL_W-1:0]  ch_sel;
  logic              bcast_store;
  logic              powerdown_flag;
  logic              rsv_set;
  qdfl_entry_t       frame_entry;
  qdfl_entry_t       clear_entry;

  assign load_cmd_hi    = cap_q[LOAD_CMD_HI_BIT];
  assign load_cmd_lo    = cap_q[LOAD_CMD_LO_BIT];
  assign load_cmd       = {load_cmd_hi, load_cmd_lo};
  assign ch_sel         = cap_q[SEL_HI_BIT:SEL_LO_BIT];
  assign bcast_store    = cap_q[SEL_HI_BIT];
  assign powerdown_flag = cap_q[POWERDOWN_FLAG_BIT];
  assign rsv_set        = cap_q[RSV_HI_BIT] | cap_q[RSV_LO_BIT];
  assign frame_entry    = '{pd: powerdown_flag, word: cap_q[CODE_W-1:0]};
  assign clear_entry    = '{pd: 1'b0, word: clear_code};

  // ----------------------------------------
  // Per-channel store and load enables
  // ----------------------------------------
  logic [NUM_CH-1:0] sel_hot;
  logic [NUM_CH-1:0] store_en;
  logic [NUM_CH-1:0] load_frame_en;
  logic [NUM_CH-1:0] load_buf_en;

  always_comb
  begin
    store_en      = '0;
    load_frame_en = '0;
    load_buf_en   = '0;
    if (apply_q && !init)
    begin
      case (load_cmd)
        CMD_STORE:
        begin
          store_en = sel_hot;
        end
        CMD_STORE_LOAD:
        begin
          store_en      = sel_hot;
          load_frame_en = sel_hot;
        end
        CMD_STORE_LOAD_ALL:
        begin
          store_en      = sel_hot;
          load_frame_en = sel_hot;
          load_buf_en   = ~sel_hot;
        end
        CMD_BROADCAST:
        begin
          if (bcast_store)
          begin
            store_en      = '1;
            load_frame_en = '1;
          end
          else
            load_buf_en = '1;
        end
        default:
        begin
          store_en      = '0;
          load_frame_en = '0;
          load_buf_en   = '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status pulses
  // ----------------------------------------
  logic applied_q;
  logic applied_d;
  logic fmt_err_q;
  logic fmt_err_d;

  always_comb
  begin
    applied_d = apply_q & ~init;
    fmt_err_d = apply_q & ~init & rsv_set;
  end

  always_ff @(posedge clock)
  begin
    applied_q <= applied_d;
    fmt_err_q <= fmt_err_d;
  end

  assign frame_applied    = applied_q;
  assign frame_format_err = fmt_err_q;

  // ----------------------------------------
  // Channel buffers and channel registers
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++)
    begin : g_ch
      localparam logic [SEL_W-1:0] IDX = SEL_W'(i);
      qdfl_entry_t buf_q;
      qdfl_entry_t buf_d;
      qdfl_entry_t dac_q;
      qdfl_entry_t dac_d;

      assign sel_hot[i] = (ch_sel == IDX);

      always_comb
      begin
        buf_d = buf_q;
        dac_d = dac_q;
        if (init)
        begin
          buf_d = clear_entry;
          dac_d = clear_entry;
        end
        else
        begin
          if (store_en[i])
            buf_d = frame_entry;
          if (load_frame_en[i])
            dac_d = frame_entry;
          else if (load_buf_en[i])
            dac_d = buf_q;
        end
      end

      always_ff @(posedge clock)
      begin
        buf_q <= buf_d;
        dac_q <= dac_d;
      end

      // Clear overrides the registers combinationally for an immediate response
      assign ch_code[i]         = clr_hold_q ? clear_code : dac_q.word;
      assign ch_powered_down[i] = ~clr_hold_q & dac_q.pd;
      assign ch_pd_mode[i]      = (clr_hold_q | ~dac_q.pd) ? 2'h0 :
                                  dac_q.word[PD_MODE_HI_BIT:PD_MODE_LO_BIT];
    end
  endgenerate

endmodule : qdfl_top

// file: qdfl_pkg.sv
// Constants and types shared by the quad converter serial frame loader
package qdfl_pkg;

  localparam int FRAME_W = 24;
  localparam int CNT_W = 5;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam int SEL_W = 2;

  // ----------------------------------------
  // Frame field positions
  // ----------------------------------------
  localparam int RSV_HI_BIT = 23;
  localparam int RSV_LO_BIT = 22;
  localparam int LOAD_CMD_HI_BIT = 21;
  localparam int LOAD_CMD_LO_BIT = 20;
  localparam int SEL_HI_BIT = 18;
  localparam int SEL_LO_BIT = 17;
  localparam int POWERDOWN_FLAG_BIT = 16;
  localparam int PD_MODE_HI_BIT = 15;
  localparam int PD_MODE_LO_BIT = 14;

  localparam logic [CNT_W-1:0] LAST_EDGE = 5'h17;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // ----------------------------------------
  // Clear targets
  // ----------------------------------------
  localparam logic [CODE_W-1:0] MIDSCALE_CODE = 16'h8000;
  localparam logic [CODE_W-1:0] ZEROSCALE_CODE = 16'h0000;

  // ----------------------------------------
  // Load commands
  // ----------------------------------------
  localparam logic [1:0] CMD_STORE = 2'h0;
  localparam logic [1:0] CMD_STORE_LOAD = 2'h1;
  localparam logic [1:0] CMD_STORE_LOAD_ALL = 2'h2;
  localparam logic [1:0] CMD_BROADCAST = 2'h3;

  typedef struct packed {
    logic              pd;
    logic [CODE_W-1:0] word;
  } qdfl_entry_t;

endpackage : qdfl_pkg

// file: qdfl_link_if.sv
// Carrier between the serial receiver and the core
`timescale 1ns/100ps
interface qdfl_link_if;
  logic [qdfl_pkg::FRAME_W-1:0] frame;
  logic                         done_tgl;

  modport rx   (output frame, output done_tgl);
  modport core (input frame, input done_tgl);
endinterface : qdfl_link_if

// file: qdfl_rx.sv
// Serial frame receiver on the serial clock domain
`timescale 1ns/100ps
module qdfl_rx (
  input  wire logic sclk,
  input  wire logic sync_n,
  input  wire logic sdin,
  input  wire logic clear_n,
  qdfl_link_if.rx   link
);
  import qdfl_pkg::*;

  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   cnt_d;
  logic [FRAME_W-1:0] shift_q;
  logic [FRAME_W-1:0] shift_d;
  logic [FRAME_W-1:0] frame_q;
  logic [FRAME_W-1:0] frame_d;
  logic               tgl_q;
  logic               tgl_d;

  // ----------------------------------------
  // Shift and count
  // ----------------------------------------
  always_comb
  begin
    cnt_d   = cnt_q;
    shift_d = shift_q;
    frame_d = frame_q;
    tgl_d   = tgl_q;
    if (cnt_q <= LAST_EDGE)
    begin
      shift_d = {shift_q[FRAME_W-2:0], sdin};
      cnt_d   = cnt_q + CNT_ONE;
    end
    if (cnt_q == LAST_EDGE)
    begin
      frame_d = shift_d;
      tgl_d   = ~tgl_q;
    end
  end

  // Select high holds the counter at zero: abort and restart
  always_ff @(negedge sclk or posedge sync_n)
  begin
    if (sync_n)
      cnt_q <= CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(negedge sclk)
  begin
    shift_q <= shift_d;
  end

  always_ff @(negedge sclk or negedge clear_n)
  begin
    if (!clear_n)
    begin
      frame_q <= '0;
      tgl_q   <= 1'b0;
    end
    else
    begin
      frame_q <= frame_d;
      tgl_q   <= tgl_d;
    end
  end

  assign link.frame    = frame_q;
  assign link.done_tgl = tgl_q;

endmodule : qdfl_rx

// file: qdfl_host_model.sv
// Host model driving the write link
`timescale 1ns/100ps
module qdfl_host_model (
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b0;
    sdin = 1'b0;
    #5;
    sync_n = 1'b1;
  end

  task automatic send(input logic [23:0] f, input int n, input bit hold);
    sync_n = 1'b1;
    #30;
    sync_n = 1'b0;
    #7;
    for (int i = 0; i < n; i++)
    begin
      sdin = (i < 24) ? f[23-i] : ~sdin;
      #16 sclk = 1'b0;
      #16 sclk = 1'b1;
    end
    sdin = ~sdin;
    #140;
    sync_n = hold;
    #60;
  endtask : send
endmodule : qdfl_host_model

// file: qdfl_top_checker.sv
// Port assertions for the frame loader
`timescale 1ns/100ps
module qdfl_top_checker (
  input wire logic                                         clock,
  input wire logic                                         rstn,
  input wire logic                                         sync_n,
  input wire logic                                         clear_n,
  input wire logic                                         clear_level_select,
  input wire logic [qdfl_pkg::NUM_CH-1:0][qdfl_pkg::CODE_W-1:0] ch_code,
  input wire logic [qdfl_pkg::NUM_CH-1:0]                  ch_powered_down,
  input wire logic [qdfl_pkg::NUM_CH-1:0][1:0]             ch_pd_mode,
  input wire logic                                         frame_applied,
  input wire logic                                         frame_format_err
);
  import qdfl_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  pulse_once_a: assert property (frame_applied |=> !frame_applied)
    else $error("applied pulse too long");
  format_pair_a: assert property (frame_format_err |-> frame_applied)
    else $error("format flag without frame");
  clear_mid_a: assert property ((!clear_n && clear_level_select) [*4]
    |-> ch_code == {NUM_CH{MIDSCALE_CODE}}) else $error("clear not midscale");
  clear_zero_a: assert property ((!clear_n && !clear_level_select) [*4]
    |-> ch_code == {NUM_CH{ZEROSCALE_CODE}}) else $error("clear not zero");
  clear_pd_a: assert property (!clear_n |-> ch_powered_down == 4'h0)
    else $error("power-down kept in clear");
  idle_stable_a: assert property (clear_n [*4] ##0 !frame_applied |-> $stable(ch_code))
    else $error("code moved without frame");
  pd_mode_off_a: assert property (ch_powered_down == 4'h0 |-> ch_pd_mode == 8'h00)
    else $error("mode without power-down");
  sync_idle_a: assert property (sync_n [*8] |=> !frame_applied)
    else $error("frame applied while idle");
  applied_clear_a: assert property (frame_applied |-> clear_n && $past(clear_n, 3))
    else $error("frame applied during clear");
endmodule : qdfl_top_checker

bind qdfl_top qdfl_top_checker qdfl_top_checker_i (.clock, .rstn, .sync_n, .clear_n,
  .clear_level_select, .ch_code, .ch_powered_down, .ch_pd_mode, .frame_applied,
  .frame_format_err);

// file: tb_quad_dac_serial_frame_loader.sv
// Self-checking bench for the frame loader
`timescale 1ns/100ps
module tb_quad_dac_serial_frame_loader;
  import qdfl_pkg::*;
  logic                          clock = 1'b0;
  logic                          rstn = 1'b0;
  logic                          clear_n = 1'b1;
  logic                          clear_level_select = 1'b1;
  logic                          sclk, sync_n, sdin;
  logic [NUM_CH-1:0][CODE_W-1:0] ch_code;
  logic [NUM_CH-1:0]             ch_powered_down;
  logic [NUM_CH-1:0][1:0]        ch_pd_mode;
  logic                          frame_applied, frame_format_err;
  logic [31:0]                   seed = 32'h20ED;
  logic [31:0]                   r;
  int                            fail_count = 0;
  int                            total_checks = 0;
  int                            applied_cnt = 0;
  int                            fmt_cnt = 0;
  int                            exp_fmt = 0;
  qdfl_entry_t                   bufm [NUM_CH];
  qdfl_entry_t                   outm [NUM_CH];

  always #12.5 clock = ~clock;
  qdfl_host_model qdfl_host_model_i (.sclk, .sync_n, .sdin);
  qdfl_top qdfl_top_i (.clock, .rstn, .sclk, .sync_n, .sdin, .clear_n, .clear_level_select,
    .ch_code, .ch_powered_down, .ch_pd_mode, .frame_applied, .frame_format_err);

  always @(posedge clock)
  begin
    applied_cnt <= applied_cnt + int'(frame_applied === 1'b1);
    fmt_cnt <= fmt_cnt + int'(frame_format_err === 1'b1);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic model_clear();
    for (int c = 0; c < NUM_CH; c++)
    begin
      bufm[c] = {1'b0, clear_level_select ? MIDSCALE_CODE : ZEROSCALE_CODE};
      outm[c] = bufm[c];
    end
  endtask : model_clear

  task automatic compare();
    logic [63:0] ec;
    logic [3:0]  ep;
    logic [7:0]  em;
    for (int c = 0; c < NUM_CH; c++)
    begin
      ec[c*16 +: 16] = outm[c].word;
      ep[c] = outm[c].pd;
      em[c*2 +: 2] = outm[c].pd ? outm[c].word[15:14] : 2'h0;
    end
    check("ch_code", ch_code, ec);
    check("ch_powered_down", 64'(ch_powered_down), 64'(ep));
    check("ch_pd_mode", 64'(ch_pd_mode), 64'(em));
  endtask : compare

  task automatic frame(input logic [23:0] f, input int n, input bit hold);
    int          a;
    logic [1:0]  s;
    qdfl_entry_t e;
    a = applied_cnt;
    s = f[18:17];
    e = {f[16], f[15:0]};
    qdfl_host_model_i.send(f, n, hold);
    if (n >= 24)
    begin
      a++;
      exp_fmt += int'(f[23:22] != 2'h0);
      if (f[21:20] != CMD_BROADCAST || f[18]) bufm[s] = e;
      if (f[21:20] == CMD_BROADCAST && f[18]) bufm = '{default: e};
      if (f[21:20] == CMD_STORE_LOAD) outm[s] = e;
      if (f[21:20] >= CMD_STORE_LOAD_ALL) outm = bufm;
    end
    check("applied", 64'(applied_cnt), 64'(a));
    check("format_err", 64'(fmt_cnt), 64'(exp_fmt));
    compare();
  endtask : frame

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    #600000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    model_clear();
    @(negedge clock);
    clear_n = 1'b0;
    repeat (9) @(negedge clock);
    clear_n = 1'b1;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    compare();
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      frame({2'h0, 2'(i), r[19:0]}, 24 + (i % 3), r[20]);
    end
    r = rnd();
    frame({2'h1, CMD_STORE_LOAD, r[19:0]}, 24, 1'b0);
    frame(r[23:0], 10, 1'b1);
    frame({2'h0, CMD_BROADCAST, 1'b0, 1'b1, r[17:0]}, 24, 1'b0);
    for (int lv = 0; lv < 2; lv++)
    begin
      clear_level_select = lv[0];
      repeat (4) @(negedge clock);
      clear_n = 1'b0;
      #1;
      model_clear();
      compare();
      repeat (4) @(negedge clock);
      clear_n = 1'b1;
      repeat (4) @(negedge clock);
      compare();
      r = rnd();
      frame({2'h0, CMD_STORE_LOAD_ALL, r[19:0]}, 24, 1'b0);
    end
    complete_run();
  end
endmodule : tb_quad_dac_serial_frame_loader
